// [rtl/uab_params.svh]
// Behaviour
// - setting autobaud enable starts calibration; receiver held idle meanwhile
// - divisor counter starts at first receive-line rise after start bit
// - calibration measures 55h and ends at its fifth rising edge
// - at end: count left in divisor pair, enable cleared, receive flag set
// - divisor pair counts as one 16-bit counter whatever wide select says
// - counter clocked at one eighth of the rate generator base clock
// - counter clock osc/512, osc/128 with one select, osc/32 with both
// - count starts at 1; software subtracts one afterwards
// - wake and autobaud together: measure the character after the break
// - in sleep serial clocks stop; no normal reception
// - wake-on-break works only in asynchronous mode
// - while wake armed, normal reception off, receiver idle, line watched
// - falling edge of receive line is the wake event
// - receive flag raised with wake event, async when asleep; the code sets it on the clock edge in sleep too
// - reading receive buffer clears the wake receive flag
// - wake enable cleared at rising edge ending break; then idle
`ifndef UAB_PARAMS_SVH
`define UAB_PARAMS_SVH
`define UAB_REG_CONTROL   4'h0
`define UAB_REG_DIV_LOW   4'h1
`define UAB_REG_DIV_HIGH  4'h2
`define UAB_REG_BUFFER    4'h3
`define UAB_REG_STATUS    4'h4
`define UAB_CTL_AUTOBAUD  0
`define UAB_CTL_WAKE      1
`define UAB_CTL_WIDE      2
`define UAB_CTL_HSPEED    3
`define UAB_CTL_SYNC      4
`define UAB_ST_FLAG       0
`define UAB_ST_IDLE       1
`define UAB_ST_MEASURE    2
`define UAB_DIV_RESET     16'h0000
`define UAB_COUNT_START   16'h0001
`define UAB_RISE_LAST     3'h5
`define UAB_PRE_512       10'h1FF
`define UAB_PRE_128       10'h07F
`define UAB_PRE_32        10'h01F
`endif

// [rtl/uab_pkg.sv]
package uab_pkg;
   typedef enum logic [1:0] {
      UAB_IDLE  = 2'b00,
      UAB_START = 2'b01,
      UAB_COUNT = 2'b10,
      UAB_BREAK = 2'b11
   } uab_state_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } uab_bus_t;

   typedef struct packed {
      logic autobaud;
      logic wake;
      logic wide;
      logic hspeed;
      logic sync;
   } uab_ctl_t;
endpackage

// [rtl/uab_prescale.sv]
`timescale 1ns/1ps
`default_nettype none
`include "uab_params.svh"
// divides the oscillator down to the autobaud counter tick
module uab_prescale
   import uab_pkg::*;
(
   // clock and reset
   input  wire logic clock,
   input  wire logic rst_b,
   // control
   input  wire logic run,
   input  wire logic wide,
   input  wire logic hspeed,
   // tick out
   output var  logic tick
);
   typedef struct packed {
      logic [9:0] cnt;
      logic       tick;
   } uab_pre_t;

   uab_pre_t st;
   uab_pre_t next_st;
   logic [9:0] last;

   // terminal count from the two selects
   always_comb begin
      if (wide && hspeed) begin
         last = `UAB_PRE_32;
      end else if (wide || hspeed) begin
         last = `UAB_PRE_128;
      end else begin
         last = `UAB_PRE_512;
      end
   end

   // base-clock divide times eight in one counter
   always_comb begin
      next_st      = st;
      next_st.tick = 1'b0;
      if (!run) begin
         next_st.cnt = 10'h000;
      end else if (st.cnt >= last) begin
         next_st.cnt  = 10'h000;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 10'h001;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick = st.tick;
endmodule
`default_nettype wire

// [rtl/uab_autobaud.sv]
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "uab_params.svh"
// autobaud measurement and wake-on-break helper
module uab_autobaud
   import uab_pkg::*;
(
   // clock and reset
   input  wire logic     clock,
   input  wire logic     rst_b,
   // register port
   input  wire uab_bus_t bus,
   output var  logic [7:0] rdata,
   // serial pin
   input  wire logic     receive_line,
   // power state
   input  wire logic     asleep,
   // receive buffer from the main receiver
   input  wire logic [7:0] receive_buffer,
   // status out
   output var  logic     receive_flag,
   output var  logic     receiver_idle_flag,
   output var  logic     receive_hold,
   output var  logic     wake_request
);
   typedef struct packed {
      logic [1:0]  sync;
      logic        lineD;
      uab_state_t  fsm;
      uab_ctl_t    ctl;
      logic [15:0] divisor;
      logic [2:0]  rises;
      logic        flag;
      logic [7:0]  rdata;
      logic        wakeReq;
   } uab_reg_t;

   uab_reg_t st;
   uab_reg_t next_st;
   logic     tick;
   logic     lineNow;
   logic     rise;
   logic     fall;
   logic     wakeArmed;

   // line passes two flops before any logic sees it
   assign lineNow   = st.sync[1];
   assign rise      = lineNow && !st.lineD;
   assign fall      = !lineNow && st.lineD;
   // wake only in asynchronous mode
   assign wakeArmed = st.ctl.wake && !st.ctl.sync;

   uab_prescale u_pre (
      .clock  (clock),
      .rst_b  (rst_b),
      .run    (st.fsm == UAB_COUNT),
      .wide   (st.ctl.wide),
      .hspeed (st.ctl.hspeed),
      .tick   (tick)
   );

   // next state: registers, measurement and wake
   always_comb begin
      next_st         = st;
      next_st.sync    = {st.sync[0], receive_line};
      next_st.lineD   = lineNow;
      next_st.wakeReq = 1'b0;
      next_st.rdata   = 8'h00;

      // register writes
      if (bus.wr) begin
         unique case (bus.addr)
            `UAB_REG_CONTROL: begin
               next_st.ctl.autobaud = bus.wdata[`UAB_CTL_AUTOBAUD];
               next_st.ctl.wake     = bus.wdata[`UAB_CTL_WAKE];
               next_st.ctl.wide     = bus.wdata[`UAB_CTL_WIDE];
               next_st.ctl.hspeed   = bus.wdata[`UAB_CTL_HSPEED];
               next_st.ctl.sync     = bus.wdata[`UAB_CTL_SYNC];
            end
            `UAB_REG_DIV_LOW: begin
               next_st.divisor[7:0] = bus.wdata;
            end
            `UAB_REG_DIV_HIGH: begin
               next_st.divisor[15:8] = bus.wdata;
            end
            default: begin
            end
         endcase
      end

      // register reads; buffer read clears the flag
      if (bus.rd) begin
         unique case (bus.addr)
            `UAB_REG_CONTROL: begin
               next_st.rdata = {3'b000, st.ctl.sync, st.ctl.hspeed,
                                st.ctl.wide, st.ctl.wake, st.ctl.autobaud};
            end
            `UAB_REG_DIV_LOW: begin
               next_st.rdata = st.divisor[7:0];
            end
            `UAB_REG_DIV_HIGH: begin
               next_st.rdata = st.divisor[15:8];
            end
            `UAB_REG_BUFFER: begin
               next_st.rdata = receive_buffer;
               next_st.flag  = 1'b0;
            end
            `UAB_REG_STATUS: begin
               next_st.rdata = {5'b00000, (st.fsm == UAB_COUNT),
                                (st.fsm == UAB_IDLE), st.flag};
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end

      // measurement and wake sequencing
      unique case (st.fsm)
         UAB_IDLE: begin
            if (wakeArmed && fall) begin
               next_st.fsm     = UAB_BREAK;
               next_st.flag    = 1'b1;
               next_st.wakeReq = 1'b1;
            end else if (st.ctl.autobaud && !wakeArmed && fall) begin
               // start bit of the sync character
               next_st.fsm = UAB_START;
            end
         end
         UAB_START: begin
            if (!st.ctl.autobaud) begin
               next_st.fsm = UAB_IDLE;
            end else if (rise) begin
               next_st.fsm     = UAB_COUNT;
               next_st.divisor = `UAB_COUNT_START;
               next_st.rises   = 3'h1;
            end
         end
         UAB_COUNT: begin
            if (tick) begin
               next_st.divisor = st.divisor + 16'h0001;
            end
            if (rise) begin
               next_st.rises = st.rises + 3'h1;
               if (st.rises + 3'h1 == `UAB_RISE_LAST) begin
                  next_st.fsm          = UAB_IDLE;
                  next_st.ctl.autobaud = 1'b0;
                  next_st.flag         = 1'b1;
               end
            end
         end
         UAB_BREAK: begin
            // wait for break to end, then measure what follows if autobaud is set
            if (rise) begin
               next_st.ctl.wake = 1'b0;
               next_st.fsm      = UAB_IDLE;
            end
         end
         default: begin
            next_st.fsm = UAB_IDLE;
         end
      endcase

      // sleep stops the measuring clock path
      if (asleep && st.fsm != UAB_BREAK && !(wakeArmed && fall)) begin
         next_st.fsm = (st.fsm == UAB_COUNT) ? UAB_IDLE : st.fsm;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         st       <= '0;
         st.sync  <= 2'b11;
         st.lineD <= 1'b1;
         st.fsm   <= UAB_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from state
   assign rdata              = st.rdata;
   assign receive_flag       = st.flag;
   assign wake_request       = st.wakeReq;
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         receiver_idle_flag <= 1'b1;
         receive_hold       <= 1'b0;
      end else begin
         receiver_idle_flag <= (next_st.fsm == UAB_IDLE);
         // normal receiver held idle while measuring or waiting on wake
         receive_hold <= next_st.ctl.autobaud || next_st.ctl.wake;
      end
   end
endmodule
`default_nettype wire

// [dv/uab_autobaud_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "uab_params.svh"
// port-level checks of flag, pulse and read answer
module uab_autobaud_monitor
   import uab_pkg::*;
(
   // clock and reset
   input wire logic       clock,
   input wire logic       rst_b,
   // watched ports
   input wire uab_bus_t   bus,
   input wire logic [7:0] rdata,
   input wire logic       receive_line,
   input wire logic [7:0] receive_buffer,
   input wire logic       receive_flag,
   input wire logic       receive_hold,
   input wire logic       wake_request
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // buffer read: the only way the flag drops
   property p_flag_fall;
      $fell(receive_flag) |->
         $past(bus.rd) && $past(bus.addr) == `UAB_REG_BUFFER;
   endproperty
   a_flag_fall: assert property (p_flag_fall)
      else $error("flag fell without buffer read");
   property p_flag_keep;
      receive_flag && !(bus.rd && bus.addr == `UAB_REG_BUFFER)
         |=> receive_flag;
   endproperty
   a_flag_keep: assert property (p_flag_keep)
      else $error("flag lost");
   // flag is set only by a wake event or the end of a measurement
   property p_flag_cause;
      $rose(receive_flag) |-> wake_request || $fell(receive_hold);
   endproperty
   a_flag_cause: assert property (p_flag_cause)
      else $error("flag set without cause");
   property p_buf_data;
      bus.rd && bus.addr == `UAB_REG_BUFFER |=>
         rdata == $past(receive_buffer);
   endproperty
   a_buf_data: assert property (p_buf_data)
      else $error("buffer read data");
   property p_rd_only;
      !$past(bus.rd) |-> rdata == 8'h00;
   endproperty
   a_rd_only: assert property (p_rd_only)
      else $error("read data outside answer");
   property p_wake_pulse;
      wake_request |=> !wake_request;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse)
      else $error("wake pulse too long");
   property p_wake_flag;
      wake_request |-> receive_flag && receive_hold;
   endproperty
   a_wake_flag: assert property (p_wake_flag)
      else $error("wake without flag or hold");
   // line latency is three edges; the break holds it low longer
   property p_wake_edge;
      wake_request |->
         $past(receive_line, 3) == 1'b0 || $past(receive_line, 4) == 1'b0;
   endproperty
   a_wake_edge: assert property (p_wake_edge)
      else $error("wake with line high");
   property p_hold_rise;
      $rose(receive_hold) |->
         $past(bus.wr) && $past(bus.addr) == `UAB_REG_CONTROL;
   endproperty
   a_hold_rise: assert property (p_hold_rise)
      else $error("hold rose without control write");
   c_wake: cover property (wake_request);
   c_done: cover property ($fell(receive_hold) && receive_flag);
   c_clear: cover property ($fell(receive_flag));
endmodule
bind uab_autobaud uab_autobaud_monitor uab_autobaud_monitor_i (
   .clock(clock), .rst_b(rst_b), .bus(bus), .rdata(rdata),
   .receive_line(receive_line), .receive_buffer(receive_buffer),
   .receive_flag(receive_flag), .receive_hold(receive_hold),
   .wake_request(wake_request));
`default_nettype wire

// [dv/uab_remote_node.sv]
`timescale 1ns/1ps
`default_nettype none
// far serial node; line idles high as with a pull-up
module uab_remote_node (
   // clock
   input  wire logic clock,
   // serial line
   output var  logic line
);
   initial line = 1'b1;
   // start, eight bits lsb first, stop; per kept measurable
   task automatic send(input logic [7:0] b, input int per);
      for (int k = 0; k < 10; k++) begin
         @(posedge clock);
         line <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : b[k-1];
         repeat (per - 1) @(posedge clock);
      end
   endtask
   // all-zero wake character, at least ten bits long
   task automatic brk(input int len);
      @(posedge clock);
      line <= 1'b0;
      repeat (len) @(posedge clock);
      line <= 1'b1;
      repeat (8) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// [dv/uab_autobaud_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "uab_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("wrong value at %0t check %0d", $time, n_checks); end end
module uab_autobaud_tb
   import uab_pkg::*;
;
   typedef struct {logic wd; logic hs; int per; logic [15:0] ex;} uab_row_t;
   logic       clock = 0, rst_b = 0, asleep = 0, wakeSeen = 0;
   logic       line, flag, idle, hold, wreq;
   logic [7:0] rdata, c, lo, hi;
   uab_bus_t   bus = '0;
   int         err_total = 0, n_checks = 0, cyc = 0;
   // bit period is 17/16 of a tick so eight ticks land cleanly
   uab_row_t   rows[4] = '{'{0, 0, 544, 16'h0009}, '{0, 1, 136, 16'h0009},
                           '{1, 0, 136, 16'h0009}, '{1, 1, 34, 16'h0009}};
   uab_autobaud uab_autobaud_i (.clock(clock), .rst_b(rst_b), .bus(bus),
      .rdata(rdata), .receive_line(line), .asleep(asleep),
      .receive_buffer(8'hA5), .receive_flag(flag),
      .receiver_idle_flag(idle), .receive_hold(hold), .wake_request(wreq));
   uab_remote_node uab_remote_node_i (.clock(clock), .line(line));
   initial forever #2.5 clock = ~clock;
   // catch the one-cycle wake pulse; cut a hang short
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (wreq === 1'b1) wakeSeen <= 1'b1;
      if (cyc == 30000) begin
         err_total++;
         close_out();
      end
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      bus <= '0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clock);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      bus <= '0;
      #1 d = rdata;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      #1 `CHK({idle, flag, hold, wreq}, 4'b1000)
      rd(4'hF, c);
      `CHK(c, 8'h00)
      $display("reset test done");
      foreach (rows[i]) begin
         wr(`UAB_REG_CONTROL, {4'h0, rows[i].hs, rows[i].wd, 2'b01});
         #1 `CHK(hold, 1'b1)
         uab_remote_node_i.send(8'h55, rows[i].per);
         `CHK(flag, 1'b1)
         rd(`UAB_REG_DIV_LOW, lo);
         rd(`UAB_REG_DIV_HIGH, hi);
         `CHK({hi, lo}, rows[i].ex)
         `CHK(hi, 8'h00)
         rd(`UAB_REG_CONTROL, c);
         `CHK(c[0], 1'b0)
         rd(`UAB_REG_BUFFER, c);
         `CHK({c, flag}, 9'h14A)
         $display("row %0d done", i);
      end
      // wake while asleep, autobaud armed too
      @(posedge clock) asleep <= 1'b1;
      `CHK(idle, 1'b1)
      wr(`UAB_REG_CONTROL, 8'h0B);
      uab_remote_node_i.brk(12 * 136);
      `CHK({wakeSeen, flag}, 2'b11)
      rd(`UAB_REG_CONTROL, c);
      `CHK(c[1:0], 2'b01)
      @(posedge clock) asleep <= 1'b0;
      rd(`UAB_REG_BUFFER, c);
      `CHK(flag, 1'b0)
      uab_remote_node_i.send(8'h55, 136);
      rd(`UAB_REG_DIV_LOW, lo);
      rd(`UAB_REG_DIV_HIGH, hi);
      `CHK({flag, hi, lo}, 17'h10009)
      rd(`UAB_REG_BUFFER, c);
      $display("wake test done");
      // synchronous mode: no wake
      wakeSeen = 1'b0;
      wr(`UAB_REG_CONTROL, 8'h12);
      uab_remote_node_i.brk(12 * 136);
      `CHK({wakeSeen, flag}, 2'b00)
      wr(`UAB_REG_CONTROL, 8'h00);
      $display("sync test done");
      close_out();
   end
endmodule
`default_nettype wire
